// File: verilog/adc_ctl_pkg.sv
// constants, field widths, reset values and state codes of the serial converter control
// assumes clk_in at 125 MHz stands in for the converter's free-running system clock
// ****************************************************************
// Notes on behaviour
// ****************************************************************
package adc_ctl_pkg;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int                 SYS_CLK_HZ = 125_000_000;
    localparam int                 INT_CLK_HZ = 4_000_000;
    localparam int                 TICK_DIV   = SYS_CLK_HZ / INT_CLK_HZ;
    localparam int                 TICK_W     = 5;
    localparam logic [TICK_W-1:0]  TICK_LAST  = TICK_W'(TICK_DIV - 1);
    localparam logic [TICK_W-1:0]  TICK_HALF  = TICK_W'(TICK_DIV / 2);
    localparam int                 CONV_TICKS = 36;
    localparam int                 EOC_TICKS  = 40;
    localparam int                 CONV_W     = 6;
    localparam logic [CONV_W-1:0]  CONV_LAST  = CONV_W'(CONV_TICKS - 1);
    localparam logic [CONV_W-1:0]  EOC_LAST   = CONV_W'(EOC_TICKS - 1);

    // ****************************************************************
    // serial access
    // ****************************************************************
    localparam int                 RESULT_W    = 8;
    localparam int                 BIT_W       = 3;
    localparam logic [BIT_W-1:0]   MSB_IDX     = BIT_W'(RESULT_W - 1);
    localparam int                 CHAN_W      = 5;
    localparam int                 FALL_W      = 4;
    localparam int                 RISE_W      = 2;
    localparam logic [FALL_W-1:0]  BURST_LEN   = 4'h8;
    localparam logic [FALL_W-1:0]  SAMPLE_FALL = 4'h4;
    localparam logic [RISE_W-1:0]  ADDR_EDGES  = 2'h3;
    localparam logic [RISE_W-1:0]  CS_RISES    = 2'h2;
    localparam logic [CHAN_W-1:0]  SELF_TEST_CODE = 5'h16;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic               EOC_RST = 1'b1;
    localparam logic               CS_N_RST = 1'b1;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACCESS,
        ST_CONVERT
    } ctl_state_t;

endpackage

// File: verilog/sync_bit.sv
// two flip-flop synchroniser for a bundle of levels
// assumes each bit is a level or a gray-coded word that moves one bit at a time
module sync_bit
    import adc_ctl_pkg::*;
#(
    parameter int              W       = 1,
    parameter logic [W-1:0]    RST_VAL = '0
) (
    // clock and reset
    input  wire logic          clk_in,
    input  wire logic          nrst_in,
    // level in and out
    input  wire logic [W-1:0]  d_in,
    output logic      [W-1:0]  q_out
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] q;
    } sync_t;

    sync_t st;
    sync_t next_st;

    always_comb begin
        next_st      = st;
        next_st.meta = d_in;
        next_st.q    = st.meta;
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            st.meta <= RST_VAL;
            st.q    <= RST_VAL;
        end else begin
            st <= next_st;
        end
    end

    assign q_out = st.q;

endmodule

// File: verilog/serial_adc_access_control.sv
// control logic of an eight-bit serial converter: select filter, serial shift, sample, hold, conversion timing
// assumes the host clock is idle while select is high or a conversion runs; the converter core is outside
module serial_adc_access_control
    import adc_ctl_pkg::*;
(
    // system clock and reset
    input  wire logic                 clk_in,
    input  wire logic                 nrst_in,
    // host serial pins
    input  wire logic                 io_clk_in,
    input  wire logic                 cs_n_in,
    input  wire logic                 addr_in,
    output logic                      data_out_out,
    output logic                      data_oe_out,
    output logic                      eoc_out,
    // analog side
    input  wire logic [RESULT_W-1:0]  conv_data_in,
    output logic                      sample_out,
    output logic                      hold_out,
    output logic      [CHAN_W-1:0]    chan_out,
    output logic                      self_test_out
);

    // ****************************************************************
    // state types
    // ****************************************************************
    typedef struct packed {
        ctl_state_t            state;
        logic [TICK_W-1:0]     div;
        logic                  cs_rec;
        logic [RISE_W-1:0]     rec_rises;
        logic                  rec_fall;
        logic                  cs_gone;
        logic [CONV_W-1:0]     tick_cnt;
        logic [RESULT_W-1:0]   result;
        logic [CHAN_W-1:0]     chan;
        logic                  link_run;
        logic                  data_out;
        logic                  data_oe;
        logic                  eoc;
        logic                  sample;
        logic                  hold;
        logic                  self_test;
    } sys_t;

    typedef struct packed {
        logic [RISE_W-1:0]     rises;
        logic [CHAN_W-1:0]     addr;
    } rise_t;

    typedef struct packed {
        logic [FALL_W-1:0]     cnt;
        logic [FALL_W-1:0]     gray;
    } fall_t;

    sys_t                st;
    sys_t                next_st;
    rise_t               rs;
    rise_t               next_rs;
    fall_t               fs;
    fall_t               next_fs;
    logic                link_run;
    logic                cs_n_s;
    logic                cs_low;
    logic [FALL_W-1:0]   fall_g_s;
    logic [FALL_W-1:0]   fall_bin;
    logic [BIT_W-1:0]    fall_idx;
    logic [CHAN_W-1:0]   link_addr;
    logic                int_rise;
    logic                int_fall;
    logic                abort;

    function automatic logic [FALL_W-1:0] gray_to_bin(input logic [FALL_W-1:0] g);
        logic [FALL_W-1:0] b;
        b[FALL_W-1] = g[FALL_W-1];
        for (int i = FALL_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    // ****************************************************************
    // crossings into the system domain
    // ****************************************************************
    sync_bit #(
        .W       (1),
        .RST_VAL (CS_N_RST)
    ) u_cs_sync (
        .clk_in  (clk_in),
        .nrst_in (nrst_in),
        .d_in    (cs_n_in),
        .q_out   (cs_n_s)
    );

    sync_bit #(
        .W       (FALL_W),
        .RST_VAL ('0)
    ) u_fall_sync (
        .clk_in  (clk_in),
        .nrst_in (nrst_in),
        .d_in    (fs.gray),
        .q_out   (fall_g_s)
    );

    assign cs_low    = ~cs_n_s;
    assign fall_bin  = gray_to_bin(fall_g_s);
    assign fall_idx  = fall_bin[BIT_W-1:0];
    // address is static from the third rise until the link is next reset
    assign link_addr = rs.addr;
    assign link_run  = st.link_run;

    // ****************************************************************
    // link domain: host serial clock
    // ****************************************************************
    always_comb begin
        next_rs = rs;
        if (rs.rises != ADDR_EDGES) begin
            next_rs.rises = rs.rises + RISE_W'(1);
            next_rs.addr  = {rs.addr[CHAN_W-2:0], addr_in};
        end
        next_fs = fs;
        if (fs.cnt != BURST_LEN) begin
            next_fs.cnt = fs.cnt + FALL_W'(1);
        end
        next_fs.gray = next_fs.cnt ^ (next_fs.cnt >> 1);
    end

    // held in reset outside an access, so the pins are ignored while select is high
    always_ff @(posedge io_clk_in or negedge link_run) begin
        if (!link_run) begin
            rs <= '0;
        end else begin
            rs <= next_rs;
        end
    end

    always_ff @(negedge io_clk_in or negedge link_run) begin
        if (!link_run) begin
            fs <= '0;
        end else begin
            fs <= next_fs;
        end
    end

    // ****************************************************************
    // system domain
    // ****************************************************************
    assign int_rise = (st.div == TICK_LAST);
    assign int_fall = (st.div == TICK_HALF);
    assign abort    = (st.state == ST_CONVERT) && st.cs_gone && next_st.cs_rec;

    always_comb begin
        next_st     = st;
        next_st.div = int_rise ? '0 : st.div + TICK_W'(1);

        // select filter, same for both directions
        if (cs_low != st.cs_rec) begin
            if (int_rise && st.rec_rises != CS_RISES) begin
                next_st.rec_rises = st.rec_rises + RISE_W'(1);
            end
            if (int_fall) begin
                next_st.rec_fall = 1'b1;
            end
            if (next_st.rec_rises == CS_RISES && next_st.rec_fall) begin
                next_st.cs_rec    = cs_low;
                next_st.rec_rises = '0;
                next_st.rec_fall  = 1'b0;
            end
        end else begin
            next_st.rec_rises = '0;
            next_st.rec_fall  = 1'b0;
        end

        // output driven only while select is low now and recognized
        next_st.data_oe = cs_low && next_st.cs_rec;

        case (st.state)
            ST_IDLE: begin
                if (next_st.cs_rec) begin
                    next_st.state    = ST_ACCESS;
                    next_st.link_run = 1'b1;
                end
            end
            ST_ACCESS: begin
                if (!next_st.cs_rec) begin
                    next_st.state    = ST_IDLE;
                    next_st.link_run = 1'b0;
                    next_st.sample   = 1'b0;
                end else if (fall_bin == BURST_LEN) begin
                    next_st.state    = ST_CONVERT;
                    next_st.link_run = 1'b0;
                    next_st.sample   = 1'b0;
                    next_st.hold     = 1'b1;
                    next_st.eoc      = 1'b0;
                    next_st.tick_cnt = '0;
                    next_st.cs_gone  = 1'b0;
                end else begin
                    if (fall_bin >= SAMPLE_FALL && !st.sample) begin
                        next_st.chan = link_addr;
                    end
                    next_st.sample = (fall_bin >= SAMPLE_FALL);
                end
            end
            ST_CONVERT: begin
                if (!next_st.cs_rec) begin
                    next_st.cs_gone = 1'b1;
                end
                if (st.cs_gone && next_st.cs_rec) begin
                    next_st.state    = ST_ACCESS;
                    next_st.link_run = 1'b1;
                    next_st.hold     = 1'b0;
                    next_st.eoc      = 1'b1;
                end else if (int_rise) begin
                    // serial clock assumed idle here, the link stays in reset
                    next_st.tick_cnt = st.tick_cnt + CONV_W'(1);
                    if (st.tick_cnt == CONV_LAST) begin
                        next_st.result = conv_data_in;
                        next_st.hold   = 1'b0;
                    end
                    if (st.tick_cnt == EOC_LAST) begin
                        next_st.eoc = 1'b1;
                        if (next_st.cs_rec) begin
                            next_st.state    = ST_ACCESS;
                            next_st.link_run = 1'b1;
                        end else begin
                            next_st.state = ST_IDLE;
                        end
                    end
                end
            end
            default: begin
                next_st.state = ST_IDLE;
            end
        endcase

        if (st.state == ST_ACCESS && fall_bin < BURST_LEN) begin
            next_st.data_out = st.result[MSB_IDX - fall_idx];
        end else begin
            next_st.data_out = next_st.result[MSB_IDX];
        end
        next_st.self_test = (next_st.chan == SELF_TEST_CODE);
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            st     <= '0;
            st.eoc <= EOC_RST;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign data_out_out  = st.data_out;
    assign data_oe_out   = st.data_oe;
    assign eoc_out       = st.eoc;
    assign sample_out    = st.sample;
    assign hold_out      = st.hold;
    assign chan_out      = st.chan;
    assign self_test_out = st.self_test;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    sequence s_eighth_fall;
        st.state == ST_ACCESS && fall_bin == BURST_LEN && next_st.cs_rec;
    endsequence

    sequence s_hold_start;
        st.state == ST_CONVERT && hold_out && !eoc_out && !sample_out && data_out_out == st.result[MSB_IDX];
    endsequence

    property p_hiz;
        cs_n_s |=> !data_oe_out;
    endproperty
    a_hiz: assert property (p_hiz) else $error("output enabled while select high");

    property p_recog;
        !cs_n_s && !st.cs_rec |-> ##[1:100] (st.cs_rec || cs_n_s);
    endproperty
    a_recog: assert property (p_recog) else $error("select low not recognized in time");

    property p_recog_early;
        st.state == ST_IDLE && next_st.state == ST_ACCESS |->
            (st.rec_rises == CS_RISES || int_rise) && (st.rec_fall || int_fall);
    endproperty
    a_recog_early: assert property (p_recog_early) else $error("select recognized too early");

    property p_msb;
        st.state == ST_ACCESS && fall_bin == '0 |=> data_out_out == st.result[MSB_IDX];
    endproperty
    a_msb: assert property (p_msb) else $error("msb not presented at access start");

    property p_shift;
        st.state == ST_ACCESS && fall_bin != '0 && fall_bin < BURST_LEN
            |=> data_out_out == st.result[MSB_IDX - $past(fall_idx)];
    endproperty
    a_shift: assert property (p_shift) else $error("wrong result bit shifted out");

    property p_eighth;
        s_eighth_fall |=> s_hold_start;
    endproperty
    a_eighth: assert property (p_eighth) else $error("eighth fall did not start hold");

    property p_sample;
        st.state == ST_ACCESS && next_st.cs_rec && fall_bin >= SAMPLE_FALL && fall_bin < BURST_LEN
            |=> sample_out;
    endproperty
    a_sample: assert property (p_sample) else $error("sampling window wrong");

    property p_chan;
        $rose(sample_out) |-> chan_out == $past(link_addr);
    endproperty
    a_chan: assert property (p_chan) else $error("channel not taken at acquisition");

    property p_result;
        st.state == ST_CONVERT && int_rise && st.tick_cnt == CONV_LAST && !abort
            |=> st.result == $past(conv_data_in) && !hold_out;
    endproperty
    a_result: assert property (p_result) else $error("result not latched at cycle 36");

    property p_eoc;
        st.state == ST_CONVERT && int_rise && st.tick_cnt == EOC_LAST && !abort |=> eoc_out;
    endproperty
    a_eoc: assert property (p_eoc) else $error("end of conversion not raised at 40");

    property p_abort;
        abort |=> st.state == ST_ACCESS && st.result == $past(st.result) && eoc_out;
    endproperty
    a_abort: assert property (p_abort) else $error("abort did not restart access");

    property p_self;
        $changed(chan_out) && chan_out == SELF_TEST_CODE |-> self_test_out;
    endproperty
    a_self: assert property (p_self) else $error("self test code not decoded");

endmodule

// File: bench/host_model.sv
// host side of the serial pins: chip select, serial clock bursts, address, data pin read
// assumes the bench calls its tasks just after a falling edge of clk_in
module host_model (
    // host pins
    output logic      cs_n_out,
    output logic      io_clk_out,
    output logic      addr_out,
    input  wire logic data_in
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        cs_n_out   = 1'b1;
        io_clk_out = 1'b0;
        addr_out   = 1'b1;
    end

    task automatic select(input logic lvl);
        cs_n_out = lvl;
    endtask

    // ****************************************************************
    // burst: 6 ns high pulses, each low phase 6 ns plus gap_ns, eighth high phase lengthened
    // ****************************************************************
    task automatic burst(input logic [2:0] a, input int gap_ns, input int stretch_ns, input int pulses,
                         output logic [7:0] got);
        got = 8'h00;
        for (int i = 0; i < pulses; i++) begin
            if (i < 3) begin
                addr_out = a[2-i];
            end else begin
                addr_out = ~addr_out;
            end
            #(gap_ns);
            io_clk_out = 1'b1;
            got[7-i]   = data_in;
            #(6 + ((i == 7) ? stretch_ns : 0));
            io_clk_out = 1'b0;
            #6;
        end
    endtask
endmodule

// File: bench/serial_adc_access_control_bench.sv
// self-checking bench of the serial converter control: fixed addresses, random results and pulse spacing
// assumes host_model drives the serial pins; outputs are checked at falling edges of clk_in, sample and hold during the eighth serial clock pulse
module serial_adc_access_control_bench
    import adc_ctl_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;

    logic                clk_in = 1'b0;
    logic                nrst_in;
    logic [RESULT_W-1:0] conv_data_in;
    logic                float_bit = 1'b0;
    logic [15:0]         lfsr;
    logic [7:0]          exp_res;
    logic [7:0]          conv_val;
    logic [7:0]          junk;
    int                  bad_count;
    int                  checks;
    wire                 cs_n;
    wire                 io_clk;
    wire                 addr;
    wire                 data_pin;
    wire                 data_out_out;
    wire                 data_oe_out;
    wire                 eoc_out;
    wire                 sample_out;
    wire                 hold_out;
    wire [CHAN_W-1:0]    chan_out;
    wire                 self_test_out;

    always #4 clk_in = ~clk_in;
    // released data line keeps moving so a stale bit cannot pass
    always @(posedge clk_in) float_bit <= ~float_bit;
    assign data_pin = data_oe_out ? data_out_out : float_bit;

    serial_adc_access_control serial_adc_access_control_i (
        .clk_in(clk_in), .nrst_in(nrst_in), .io_clk_in(io_clk), .cs_n_in(cs_n), .addr_in(addr),
        .data_out_out(data_out_out), .data_oe_out(data_oe_out), .eoc_out(eoc_out),
        .conv_data_in(conv_data_in), .sample_out(sample_out), .hold_out(hold_out),
        .chan_out(chan_out), .self_test_out(self_test_out));

    host_model host_model_i (.cs_n_out(cs_n), .io_clk_out(io_clk), .addr_out(addr), .data_in(data_pin));

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        if (bad_count == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic cs_drop();
        host_model_i.select(1'b0);
        repeat (20) @(negedge clk_in);
        check(data_oe_out, 1'b0);
        repeat (80) @(negedge clk_in);
        check(data_oe_out, 1'b1);
        check(data_out_out, exp_res[7]);
    endtask

    task automatic access(input logic [2:0] a);
        logic [7:0] got;
        int         stretch;
        lfsr         = lfsr_next(lfsr);
        conv_val     = lfsr[15:8];
        conv_data_in = conv_val;
        stretch      = lfsr[6] ? 200 : 0;
        fork
            host_model_i.burst(a, 60 + int'(lfsr[5:0]), stretch, 8, got);
            begin
                repeat (8) @(posedge io_clk);
                #(stretch / 2 + 3);
                check(sample_out, 1'b1);
                check(hold_out, 1'b0);
            end
        join
        check(got, exp_res);
        check({3'b000, chan_out}, {5'b00000, a});
        check(self_test_out, {2'b00, a} == SELF_TEST_CODE);
        repeat (12) @(negedge clk_in);
        check(data_out_out, exp_res[7]);
        check({eoc_out, hold_out, sample_out}, 3'b010);
    endtask

    task automatic conv_wait(input logic cs_low);
        int n_hold;
        int n_eoc;
        n_hold = 0;
        while (hold_out !== 1'b0 && n_hold < 3000) begin
            @(negedge clk_in);
            n_hold++;
        end
        n_eoc = n_hold;
        while (eoc_out !== 1'b1 && n_eoc < 3000) begin
            @(negedge clk_in);
            n_eoc++;
        end
        if (n_eoc >= 3000) begin
            bad_count++;
            $display("wrong value at %0t: conversion never ended", $time);
            test_done();
        end
        check(n_hold >= (CONV_TICKS - 2) * TICK_DIV && n_hold <= CONV_TICKS * TICK_DIV, 1'b1);
        check(n_eoc - n_hold == (EOC_TICKS - CONV_TICKS) * TICK_DIV, 1'b1);
        exp_res = conv_val;
        if (cs_low) check(data_out_out, exp_res[7]);
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        nrst_in      = 1'b0;
        conv_data_in = 8'h00;
        lfsr         = 16'hadff;
        exp_res      = 8'h00;
        bad_count    = 0;
        checks       = 0;
        repeat (3) @(posedge clk_in);
        @(negedge clk_in);
        nrst_in = 1'b1;
        @(negedge clk_in);
        check({eoc_out, data_oe_out, hold_out, sample_out, self_test_out, chan_out}, 10'h200);
        host_model_i.burst(3'h5, 60, 0, 8, junk);
        @(negedge clk_in);
        check({data_oe_out, sample_out, hold_out, chan_out}, 8'h00);
        cs_drop();
        for (int i = 0; i < 8; i++) begin
            access(3'(i));
            conv_wait(1'b1);
        end
        // select high through a whole conversion
        access(3'h2);
        host_model_i.select(1'b1);
        repeat (5) @(negedge clk_in);
        check(data_oe_out, 1'b0);
        conv_wait(1'b0);
        cs_drop();
        // short high glitch mid conversion is filtered
        access(3'h6);
        host_model_i.select(1'b1);
        repeat (10) @(negedge clk_in);
        check(data_oe_out, 1'b0);
        host_model_i.select(1'b0);
        repeat (6) @(negedge clk_in);
        check(data_oe_out, 1'b1);
        conv_wait(1'b1);
        // select toggled mid conversion aborts it
        access(3'h1);
        host_model_i.select(1'b1);
        repeat (150) @(negedge clk_in);
        cs_drop();
        check({eoc_out, hold_out}, 2'b10);
        // abort in mid access, then a fresh access from the msb
        host_model_i.burst(3'h3, 70, 0, 5, junk);
        @(negedge clk_in);
        host_model_i.select(1'b1);
        repeat (150) @(negedge clk_in);
        cs_drop();
        access(3'h4);
        conv_wait(1'b1);
        // reset in mid run with select high: result cleared, pins back to idle
        host_model_i.select(1'b1);
        repeat (10) @(negedge clk_in);
        nrst_in = 1'b0;
        repeat (3) @(negedge clk_in);
        nrst_in = 1'b1;
        exp_res = 8'h00;
        @(negedge clk_in);
        check({eoc_out, data_oe_out, hold_out, sample_out, self_test_out, chan_out}, 10'h200);
        cs_drop();
        access(3'h7);
        conv_wait(1'b1);
        test_done();
    end
endmodule
